// File: twx_consts.vh
`ifndef TWX_CONSTS_VH
`define TWX_CONSTS_VH

// data path widths and holding register count
`define TWX_PTR_W 21
`define TWX_ADDR_W 12
`define TWX_HOLD_N 8
`define TWX_HOLD_IDX_W 3

// opcode fields
`define TWX_TW_OP 14'h0003
`define TWX_TST_OP 7'h33
`define TWX_XOR_OP 8'h0a

// table write pointer modes
`define TWX_TW_KEEP 2'h0
`define TWX_TW_POSTINC 2'h1
`define TWX_TW_POSTDEC 2'h2
`define TWX_TW_PREINC 2'h3

// access bank split and indexed offset limit
`define TWX_ACC_SPLIT 8'h60
`define TWX_IDX_MAX 8'h5f
`define TWX_ACC_LO_BANK 4'h0
`define TWX_ACC_HI_BANK 4'hf

// phases of one instruction cycle
`define TWX_Q1 2'h0
`define TWX_Q2 2'h1
`define TWX_Q3 2'h2
`define TWX_Q4 2'h3

// reset values
`define TWX_PTR_RST 21'h000000
`define TWX_ACC_RST 8'h00

`endif

// File: twx_hold_regs.v
`timescale 1ns/1ps
`include "twx_consts.vh"

module twx_hold_regs
(
    input wire clock_i,
    input wire rst_n_i,
    input wire wr_en_i,
    input wire [`TWX_HOLD_IDX_W-1:0] wr_idx_i,
    input wire [7:0] wr_data_i,
    input wire [`TWX_HOLD_IDX_W-1:0] rd_idx_i,
    output reg [7:0] rd_data_o
);

    wire [8*`TWX_HOLD_N-1:0] flat_w;

    genvar gi;
    generate
        for (gi = 0; gi < `TWX_HOLD_N; gi = gi + 1)
        begin : g_hold
            reg [7:0] byte_r;
            always @(posedge clock_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    byte_r <= 8'hff;
                else if (wr_en_i && (wr_idx_i == gi))
                    byte_r <= wr_data_i;
            end
            assign flat_w[8*gi+7:8*gi] = byte_r;
        end
    endgenerate

    // staged bytes, read back only
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_data_o <= 8'h00;
        else
            rd_data_o <= flat_w[8*rd_idx_i +: 8];
    end

endmodule

// File: twx_exec.v
`timescale 1ns/1ps
`include "twx_consts.vh"

module twx_exec
(
    input wire clock_i,
    input wire rst_n_i,
    input wire [15:0] instr_i,
    input wire instr_valid_i,
    input wire next_two_word_i,
    input wire [7:0] table_latch_i,
    input wire ptr_wr_i,
    input wire [`TWX_PTR_W-1:0] ptr_wdata_i,
    input wire acc_wr_i,
    input wire [7:0] acc_wdata_i,
    input wire [3:0] bank_select_register_i,
    input wire ext_set_en_i,
    input wire [`TWX_ADDR_W-1:0] index_base_i,
    input wire [7:0] dmem_rdata_i,
    input wire [`TWX_HOLD_IDX_W-1:0] hold_rd_idx_i,
    output wire [1:0] phase_o,
    output wire instr_ack_o,
    output wire discard_o,
    output reg [`TWX_ADDR_W-1:0] dmem_addr_o,
    output reg dmem_rd_o,
    output wire [`TWX_PTR_W-1:0] table_pointer_o,
    output wire table_byte_hi_o,
    output wire [7:0] accumulator_o,
    output wire neg_o,
    output wire zero_o,
    output wire [7:0] hold_rd_data_o
);

    // states: one instruction cycle each
    localparam ST_RUN = 2'h0;
    localparam ST_TW2 = 2'h1;
    localparam ST_SKIP1 = 2'h2;
    localparam ST_SKIP2 = 2'h3;

    // decoded kinds
    localparam OP_NONE = 2'h0;
    localparam OP_TW = 2'h1;
    localparam OP_TST = 2'h2;
    localparam OP_XOR = 2'h3;

    reg [1:0] q_r;
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [1:0] op_r;
    reg [1:0] op_nxt;
    reg [15:0] ir_r;
    reg [7:0] opnd_r;
    reg [7:0] latch_r;
    reg zero_hit_r;
    reg two_word_r;
    reg [`TWX_PTR_W-1:0] table_pointer_r;
    reg [7:0] acc_r;
    reg neg_r;
    reg zero_r;
    reg hold_we_r;
    reg [`TWX_ADDR_W-1:0] eff_addr;
    reg [7:0] xor_res;

    wire [7:0] file_w;
    wire acc_bit_w;
    wire [1:0] tw_mode_w;

    assign file_w = ir_r[7:0];
    assign acc_bit_w = ir_r[8];
    assign tw_mode_w = ir_r[1:0];

    assign phase_o = q_r;
    assign table_pointer_o = table_pointer_r;
    assign table_byte_hi_o = table_pointer_r[0];
    assign accumulator_o = acc_r;
    assign neg_o = neg_r;
    assign zero_o = zero_r;

    // end of the last cycle of an instruction
    assign instr_ack_o = (q_r == `TWX_Q4) && (st_nxt == ST_RUN);
    assign discard_o = (q_r == `TWX_Q4) &&
        ((st_r == ST_SKIP1) || (st_r == ST_SKIP2));

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q_r <= `TWX_Q1;
        else
            q_r <= q_r + 2'h1;
    end

    // decode of a new word in phase one
    always @*
    begin
        op_nxt = OP_NONE;
        if (instr_valid_i)
        begin
            if (instr_i[15:2] == `TWX_TW_OP)
                op_nxt = OP_TW;
            else if (instr_i[15:9] == `TWX_TST_OP)
                op_nxt = OP_TST;
            else if (instr_i[15:8] == `TWX_XOR_OP)
                op_nxt = OP_XOR;
        end
    end

    // file address forming
    always @*
    begin
        eff_addr = {bank_select_register_i, file_w};
        if (!acc_bit_w)
        begin
            if (ext_set_en_i && (file_w <= `TWX_IDX_MAX))
                eff_addr = index_base_i + {4'h0, file_w};
            else if (file_w < `TWX_ACC_SPLIT)
                eff_addr = {`TWX_ACC_LO_BANK, file_w};
            else
                eff_addr = {`TWX_ACC_HI_BANK, file_w};
        end
    end

    always @*
    begin
        xor_res = acc_r ^ opnd_r;
    end

    // next instruction cycle
    always @*
    begin
        st_nxt = ST_RUN;
        case (st_r)
            ST_RUN:
            begin
                if (op_r == OP_TW)
                    st_nxt = ST_TW2;
                else if ((op_r == OP_TST) && zero_hit_r)
                    st_nxt = ST_SKIP1;
            end
            ST_SKIP1:
            begin
                if (two_word_r)
                    st_nxt = ST_SKIP2;
            end
            ST_TW2:
                st_nxt = ST_RUN;
            ST_SKIP2:
                st_nxt = ST_RUN;
            default:
                st_nxt = ST_RUN;
        endcase
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_r <= ST_RUN;
        else if (q_r == `TWX_Q4)
            st_r <= st_nxt;
    end

    // decode, read, process, write
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            op_r <= OP_NONE;
            ir_r <= 16'h0000;
            opnd_r <= 8'h00;
            latch_r <= 8'h00;
            zero_hit_r <= 1'b0;
            two_word_r <= 1'b0;
            dmem_addr_o <= {`TWX_ADDR_W{1'b0}};
            dmem_rd_o <= 1'b0;
            hold_we_r <= 1'b0;
        end
        else
        begin
            dmem_rd_o <= 1'b0;
            hold_we_r <= 1'b0;
            case (q_r)
                `TWX_Q1:
                begin
                    if (st_r == ST_RUN)
                    begin
                        op_r <= op_nxt;
                        ir_r <= instr_i;
                        zero_hit_r <= 1'b0;
                    end
                end
                `TWX_Q2:
                begin
                    if ((st_r == ST_RUN) && (op_r == OP_TST))
                    begin
                        dmem_addr_o <= eff_addr;
                        dmem_rd_o <= 1'b1;
                    end
                    if ((st_r == ST_RUN) && (op_r == OP_XOR))
                        opnd_r <= ir_r[7:0];
                    if (st_r == ST_TW2)
                        latch_r <= table_latch_i;
                end
                `TWX_Q3:
                begin
                    if ((st_r == ST_RUN) && (op_r == OP_TST))
                    begin
                        zero_hit_r <= (dmem_rdata_i == 8'h00);
                        two_word_r <= next_two_word_i;
                    end
                    // holding write lands in phase four
                    if (st_r == ST_TW2)
                        hold_we_r <= 1'b1;
                end
                `TWX_Q4:
                begin
                    if (st_nxt == ST_RUN)
                        op_r <= OP_NONE;
                end
                default:
                begin
                    op_r <= op_r;
                end
            endcase
        end
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            table_pointer_r <= `TWX_PTR_RST;
        else if ((q_r == `TWX_Q4) && (st_r == ST_RUN) && (op_r == OP_TW)
            && (tw_mode_w == `TWX_TW_PREINC))
            table_pointer_r <= table_pointer_r + 21'h1;
        else if ((q_r == `TWX_Q4) && (st_r == ST_TW2)
            && (tw_mode_w == `TWX_TW_POSTINC))
            table_pointer_r <= table_pointer_r + 21'h1;
        else if ((q_r == `TWX_Q4) && (st_r == ST_TW2)
            && (tw_mode_w == `TWX_TW_POSTDEC))
            table_pointer_r <= table_pointer_r - 21'h1;
        else if (ptr_wr_i)
            table_pointer_r <= ptr_wdata_i;
    end

    // accumulator and flags
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc_r <= `TWX_ACC_RST;
            neg_r <= 1'b0;
            zero_r <= 1'b0;
        end
        else if ((q_r == `TWX_Q4) && (st_r == ST_RUN)
            && (op_r == OP_XOR))
        begin
            // result and N, Z in phase four
            acc_r <= xor_res;
            neg_r <= xor_res[7];
            zero_r <= (xor_res == 8'h00);
        end
        else if (acc_wr_i)
            acc_r <= acc_wdata_i;
    end

    // holding register chosen by pointer low bits
    // staging only, no program memory write here
    twx_hold_regs u_hold
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(hold_we_r),
        .wr_idx_i(table_pointer_r[`TWX_HOLD_IDX_W-1:0]),
        .wr_data_i(latch_r),
        .rd_idx_i(hold_rd_idx_i),
        .rd_data_o(hold_rd_data_o)
    );

endmodule

// File: twx_exec_checker.sv
`timescale 1ns/1ps
`include "twx_consts.vh"
module twx_exec_checker
(
    input wire clock_i,
    input wire rst_n_i,
    input wire ptr_wr_i,
    input wire acc_wr_i,
    input wire [1:0] phase_o,
    input wire instr_ack_o,
    input wire discard_o,
    input wire dmem_rd_o,
    input wire [`TWX_PTR_W-1:0] table_pointer_o,
    input wire table_byte_hi_o,
    input wire [7:0] accumulator_o,
    input wire neg_o,
    input wire zero_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_rd_pulse;
        phase_o == `TWX_Q3 ##1 !dmem_rd_o;
    endsequence
    sequence s_ack_quiet;
        !instr_ack_o [*3];
    endsequence
    property p_phase_step;
        1'b1 |=> phase_o == $past(phase_o) + 2'h1;
    endproperty
    property p_ack_q4;
        instr_ack_o |-> phase_o == `TWX_Q4 ##1 s_ack_quiet;
    endproperty
    property p_discard;
        discard_o |-> phase_o == `TWX_Q4
            && ($past(dmem_rd_o, 5) || $past(dmem_rd_o, 9));
    endproperty
    property p_rd_pulse;
        $rose(dmem_rd_o) |-> s_rd_pulse;
    endproperty
    property p_flags;
        !$stable({neg_o, zero_o}) |-> $past(instr_ack_o)
            && zero_o == (accumulator_o == 8'h00)
            && neg_o == accumulator_o[7];
    endproperty
    property p_ptr_step;
        !$stable(table_pointer_o) && !$past(ptr_wr_i) |->
            $past(phase_o) == `TWX_Q4 &&
            (table_pointer_o == $past(table_pointer_o) + 21'h1 ||
            table_pointer_o == $past(table_pointer_o) - 21'h1);
    endproperty
    property p_byte_hi;
        table_byte_hi_o == table_pointer_o[0];
    endproperty
    property p_acc_q4;
        !$stable(accumulator_o) && !$past(acc_wr_i) |->
            $past(phase_o) == `TWX_Q4;
    endproperty
    a_phase_step: assert property (p_phase_step)
        else $error("phase order broken");
    a_ack_q4: assert property (p_ack_q4)
        else $error("ack timing wrong");
    a_discard: assert property (p_discard)
        else $error("discard timing wrong");
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("operand read pulse wrong");
    a_flags: assert property (p_flags)
        else $error("flag update wrong");
    a_ptr_step: assert property (p_ptr_step)
        else $error("pointer step wrong");
    a_byte_hi: assert property (p_byte_hi)
        else $error("byte select wrong");
    a_acc_q4: assert property (p_acc_q4)
        else $error("accumulator written off phase");
endmodule
bind twx_exec twx_exec_checker chk_i
(
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ptr_wr_i(ptr_wr_i),
    .acc_wr_i(acc_wr_i), .phase_o(phase_o), .instr_ack_o(instr_ack_o),
    .discard_o(discard_o), .dmem_rd_o(dmem_rd_o),
    .table_pointer_o(table_pointer_o), .table_byte_hi_o(table_byte_hi_o),
    .accumulator_o(accumulator_o), .neg_o(neg_o), .zero_o(zero_o)
);

// File: twx_dmem_model.sv
`timescale 1ns/1ps
`include "twx_consts.vh"
module twx_dmem_model
(
    input wire clock_i,
    input wire rd_i,
    input wire [`TWX_ADDR_W-1:0] addr_i,
    output wire [7:0] rdata_o
);
    reg [7:0] mem [0:4095];
    reg [7:0] last_r = 8'h00;
    // last byte read, kept for the idle bus
    always @(posedge clock_i)
    begin
        if (rd_i)
            last_r <= mem[addr_i];
    end
    // data stands while the read strobe is high
    // idle bus shows the inverse of the last byte
    assign rdata_o = rd_i ? mem[addr_i] : ~last_r;
endmodule

// File: table_write_test_skip_xor_exec_test.sv
`timescale 1ns/1ps
module table_write_test_skip_xor_exec_test;
    reg clock_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [15:0] ins = 16'h0000;
    reg vld = 1'b0;
    reg two = 1'b0;
    reg [7:0] lat = 8'h00;
    reg pwr = 1'b0;
    reg [20:0] pdat = 21'h000000;
    reg awr = 1'b0;
    reg [7:0] adat = 8'h00;
    reg [3:0] bank = 4'h0;
    reg ext = 1'b0;
    reg [11:0] base = 12'h000;
    reg [2:0] hidx = 3'h0;
    reg [1:0] flg;
    wire [7:0] rdat, acc, hdat;
    wire [1:0] phase;
    wire ack, disc, drd, bhi, neg, zero;
    wire [11:0] daddr;
    wire [20:0] ptr;
    integer error_cnt = 0;
    integer compares = 0;
    integer ndisc, n;
    twx_exec dut
    (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_i(ins),
        .instr_valid_i(vld), .next_two_word_i(two), .table_latch_i(lat),
        .ptr_wr_i(pwr), .ptr_wdata_i(pdat), .acc_wr_i(awr),
        .acc_wdata_i(adat), .bank_select_register_i(bank),
        .ext_set_en_i(ext), .index_base_i(base), .dmem_rdata_i(rdat),
        .hold_rd_idx_i(hidx), .phase_o(phase), .instr_ack_o(ack),
        .discard_o(disc), .dmem_addr_o(daddr), .dmem_rd_o(drd),
        .table_pointer_o(ptr), .table_byte_hi_o(bhi), .accumulator_o(acc),
        .neg_o(neg), .zero_o(zero), .hold_rd_data_o(hdat)
    );
    twx_dmem_model dm
    (
        .clock_i(clock_i), .rd_i(drd), .addr_i(daddr), .rdata_o(rdat)
    );
    initial
    begin
        forever #4 clock_i = ~clock_i;
    end
    task report_and_stop;
    begin
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: %h vs %h", $time, seen, exp);
        end
    end
    endtask
    task run(input [15:0] w, input t, input integer cyc);
        integer k;
    begin
        for (k = 0; k < 8 && phase !== 2'h0; k = k + 1)
            @(negedge clock_i);
        if (phase !== 2'h0)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: no phase one", $time);
            report_and_stop;
        end
        ins = w;
        vld = 1'b1;
        two = t;
        ndisc = 0;
        for (k = 0; k < 20 && ack !== 1'b1; k = k + 1)
        begin
            @(negedge clock_i);
            ndisc = ndisc + (disc === 1'b1);
        end
        vld = 1'b0;
        if (ack !== 1'b1)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: no ack", $time);
            report_and_stop;
        end
        chk(k, cyc);
        // results land at the edge that ends the cycle
        @(negedge clock_i);
    end
    endtask
    task ld(input [20:0] p, input [7:0] a);
    begin
        @(negedge clock_i);
        pwr = 1'b1;
        pdat = p;
        awr = 1'b1;
        adat = a;
        @(negedge clock_i);
        pwr = 1'b0;
        awr = 1'b0;
    end
    endtask
    task hrd(input [2:0] ix, input [7:0] exp);
    begin
        hidx = ix;
        @(negedge clock_i);
        @(negedge clock_i);
        chk(hdat, exp);
    end
    endtask
    task t_xor;
    begin
        ld(21'h000000, 8'hb5);
        run(16'h0aaf, 1'b0, 3);
        chk({neg, zero, acc}, {2'b00, 8'h1a});
        run(16'h0a1a, 1'b0, 3);
        chk({neg, zero, acc}, {2'b01, 8'h00});
        run(16'h0a80, 1'b0, 3);
        run(16'h0b55, 1'b0, 3);
        chk({neg, zero, acc}, {2'b10, 8'h80});
    end
    endtask
    task t_tw;
        reg [20:0] p, q, f;
    begin
        for (n = 0; n < 4; n = n + 1)
        begin
            p = n == 1 ? 21'h1fffff : n == 2 ? 21'h0 : 21'h00a356 + n;
            q = n == 3 ? p + 21'h1 : p;
            f = n == 2 ? p - 21'h1 : n == 0 ? p : p + 21'h1;
            ld(p, acc);
            lat = 8'h50 + n;
            flg = {neg, zero};
            run({14'h0003, n[1:0]}, 1'b0, 7);
            chk(ptr, f);
            chk(bhi, f[0]);
            chk({neg, zero}, flg);
            hrd(q[2:0], lat);
        end
        hrd(3'h1, 8'hff);
    end
    endtask
    task sk(input a, input [7:0] f, input [7:0] v, input t,
        input [11:0] ea, input integer cyc);
    begin
        dm.mem[ea] = v;
        flg = {neg, zero};
        run({7'h33, a, f}, t, cyc);
        chk(daddr, ea);
        chk(ndisc, (cyc - 3) / 4);
        chk({neg, zero}, flg);
    end
    endtask
    task t_skip;
    begin
        bank = 4'h3;
        base = 12'h100;
        sk(1'b0, 8'h10, 8'h05, 1'b0, 12'h010, 3);
        sk(1'b0, 8'h70, 8'h00, 1'b0, 12'hf70, 7);
        sk(1'b1, 8'h22, 8'h00, 1'b1, 12'h322, 11);
        ext = 1'b1;
        sk(1'b0, 8'h5f, 8'h00, 1'b0, 12'h15f, 7);
        sk(1'b0, 8'h60, 8'h01, 1'b1, 12'hf60, 3);
        sk(1'b1, 8'h05, 8'h00, 1'b0, 12'h305, 7);
    end
    endtask
    initial
    begin
        repeat (6) @(negedge clock_i);
        rst_n_i = 1'b1;
        chk({ptr, acc, neg, zero}, 31'h0);
        hrd(3'h1, 8'hff);
        t_xor;
        t_tw;
        t_skip;
        report_and_stop;
    end
endmodule
